// >>> src/fam_cfg.svh
// constants for the flash array address map: geometry, security space, parameter image
//Contract
//- main array decodes into 256 blocks of 64 KiB, 16 sectors each, 4096 sectors
//- array is 65536 pages of 256 bytes, each programmable on its own
//- programming only clears bits; only erase sets them back to one
//- erase works per sector, per block or whole chip; no page erase
//- each sector is aligned; upper twelve address bits select it
//- four 256-byte security registers, register n based at n times 0x1000
//- a security register whose lock bit is set is never written again
//- register 0 holds the parameter image, read by instruction 0x5A
//- registers 1 to 3 erase, program and lock without touching anything else
//- parameter space is read-only; program and erase leave it unchanged
//- parameter header starts at byte zero and points at each table
//- bytes 0x10 up to the table start are undefined header reserve
//- basic parameter table starts at offset 0x30
//- parameter space ends at 0x6F; 0x70 to 0xFF are reserved
//- offsets 0 to 3 return the signature S, F, D, P
//- header byte 4 returns minor 0x06, byte 5 returns major 0x01
`ifndef FAM_CFG_SVH
`define FAM_CFG_SVH

// ==========================================================
// array geometry
`define FAM_ARRAY_AW        24
`define FAM_PAGE_AW         8
`define FAM_SECTOR_AW       12
`define FAM_BLOCK_AW        16
`define FAM_BLOCK_COUNT     256
`define FAM_SECTOR_COUNT    4096
`define FAM_PAGE_COUNT      65536
`define FAM_SECTOR_BYTES    25'h000_1000
`define FAM_BLOCK_BYTES     25'h001_0000
`define FAM_ERASED_BYTE     8'hFF

// ==========================================================
// security register space
`define FAM_SEC_REG_COUNT   4
`define FAM_SEC_REG_LSB     12
`define FAM_SEC_BYTE_AW     8
`define FAM_SEC_AW          10
`define FAM_SEC_LAST_ADDR   24'h00_30FF
`define FAM_CMD_READ_PARAMS 8'h5A

// ==========================================================
// parameter image layout
`define FAM_HDR_BASE        8'h00
`define FAM_HDR_RSVD_BASE   8'h10
`define FAM_TABLE_BASE      8'h30
`define FAM_SPACE_END       8'h6F
`define FAM_RSVD_BASE       8'h70
`define FAM_SIG_0           8'h53
`define FAM_SIG_1           8'h46
`define FAM_SIG_2           8'h44
`define FAM_SIG_3           8'h50
`define FAM_REV_MINOR       8'h06
`define FAM_REV_MAJOR       8'h01
`define FAM_HDR_COUNT       8'h00
`define FAM_TABLE_ID        8'h00
`define FAM_TABLE_DWORDS    8'h10

`endif

// >>> src/fam_pkg.sv
// types shared by the flash array address map block
`include "fam_cfg.svh"

package fam_pkg;

    typedef enum logic [7:0] {
        op_read                      = 8'h01,
        op_program                   = 8'h02,
        op_sector_erase              = 8'h03,
        op_block_erase               = 8'h04,
        op_chip_erase                = 8'h05,
        op_sec_read                  = 8'h06,
        op_sec_program               = 8'h07,
        op_sec_erase                 = 8'h08,
        read_discoverable_params_cmd = `FAM_CMD_READ_PARAMS
    } fam_op_t;

    typedef struct packed {
        fam_op_t     op;
        logic [23:0] addr;
        logic [7:0]  data;
    } fam_req_t;

    typedef struct packed {
        logic       done;
        logic       err;
        logic [7:0] data;
    } fam_resp_t;

    typedef enum logic [5:0] {
        S_IDLE  = 6'b00_0001,
        S_READ  = 6'b00_0010,
        S_RMW   = 6'b00_0100,
        S_MOD   = 6'b00_1000,
        S_ERASE = 6'b01_0000,
        S_RESP  = 6'b10_0000
    } fam_state_t;

endpackage

// >>> src/fam_mem.sv
// byte memory with registered read data, filled with the erased value
`timescale 1ns/1ps
`default_nettype none
`include "fam_cfg.svh"

module fam_mem #(
    parameter int AW = 10
) (
    input  wire logic          core_clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];

    // power-up image of a fresh part: every cell erased
    initial begin
        for (int i = 0; i < (1<<AW); i++) begin
            mem[i] = `FAM_ERASED_BYTE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= `FAM_ERASED_BYTE;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule
`default_nettype wire

// >>> src/fam_param_rom.sv
// read-only parameter image held in security register 0
`timescale 1ns/1ps
`default_nettype none
`include "fam_cfg.svh"

module fam_param_rom #(
    parameter logic [7:0] TABLE_FILL = 8'hFF
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] addr_i,
    output logic      [7:0] data_o
);
    logic [7:0] byte_d;

    always_comb begin
        byte_d = `FAM_ERASED_BYTE;
        if (addr_i >= `FAM_RSVD_BASE) begin
            byte_d = `FAM_ERASED_BYTE;
        end else if (addr_i >= `FAM_TABLE_BASE) begin
            byte_d = TABLE_FILL;
        end else if (addr_i >= `FAM_HDR_RSVD_BASE) begin
            byte_d = `FAM_ERASED_BYTE;
        end else begin
            case (addr_i[3:0])
                4'h0:    byte_d = `FAM_SIG_0;
                4'h1:    byte_d = `FAM_SIG_1;
                4'h2:    byte_d = `FAM_SIG_2;
                4'h3:    byte_d = `FAM_SIG_3;
                4'h4:    byte_d = `FAM_REV_MINOR;
                4'h5:    byte_d = `FAM_REV_MAJOR;
                4'h6:    byte_d = `FAM_HDR_COUNT;
                4'h8:    byte_d = `FAM_TABLE_ID;
                4'h9:    byte_d = `FAM_REV_MINOR;
                4'hA:    byte_d = `FAM_REV_MAJOR;
                4'hB:    byte_d = `FAM_TABLE_DWORDS;
                4'hC:    byte_d = `FAM_TABLE_BASE;
                4'hD:    byte_d = 8'h00;
                4'hE:    byte_d = 8'h00;
                default: byte_d = `FAM_ERASED_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_o <= `FAM_ERASED_BYTE;
        end else begin
            data_o <= byte_d;
        end
    end
endmodule
`default_nettype wire

// >>> src/fam_top.sv
// flash array address map: array, security registers and parameter image access
`timescale 1ns/1ps
`default_nettype none
`include "fam_cfg.svh"

module fam_top
    import fam_pkg::*;
#(
    parameter int         ARRAY_AW   = `FAM_ARRAY_AW,
    parameter logic [7:0] TABLE_FILL = 8'hFF
) (
    input  wire logic     core_clk_i,
    input  wire logic     reset_n_i,
    input  wire logic     req_valid_i,
    input  wire fam_req_t req_i,
    input  wire logic     security_reg1_lock_i,
    input  wire logic     security_reg2_lock_i,
    input  wire logic     security_reg3_lock_i,
    output logic          req_ready_o,
    output fam_resp_t     resp_o
);
    // ==========================================================
    // address decode helpers
    localparam logic [ARRAY_AW-1:0] SECTOR_MASK =
        ARRAY_AW'((32'd1 << `FAM_SECTOR_AW) - 32'd1);
    localparam logic [ARRAY_AW-1:0] BLOCK_MASK =
        ARRAY_AW'((32'd1 << `FAM_BLOCK_AW) - 32'd1);

    function automatic logic sec_window_ok(input logic [23:0] a);
        sec_window_ok = (a[23:14] == 10'h000) && (a[11:8] == 4'h0);
    endfunction

    function automatic logic [1:0] sec_reg_of(input logic [23:0] a);
        sec_reg_of = a[13:12];
    endfunction

    function automatic logic is_sec_op(input fam_op_t o);
        is_sec_op = (o == op_sec_read) || (o == op_sec_program) || (o == op_sec_erase);
    endfunction

    // ==========================================================
    // state
    fam_state_t          state_q, state_d;
    fam_req_t            req_q, req_d;
    logic [ARRAY_AW-1:0] ptr_q, ptr_d;
    logic [ARRAY_AW-1:0] last_q, last_d;
    logic                sec_tgt_q, sec_tgt_d;
    logic                err_q, err_d;
    fam_resp_t           resp_q, resp_d;

    logic                arr_we;
    logic [ARRAY_AW-1:0] arr_waddr;
    logic [7:0]          arr_wdata;
    logic [7:0]          arr_rdata;
    logic                sec_we;
    logic [9:0]          sec_waddr;
    logic [7:0]          sec_wdata;
    logic [7:0]          sec_rdata;
    logic [7:0]          rom_rdata;
    logic [3:0]          locked;
    logic                accept;

    // register 0 is permanently read-only to the host
    assign locked      = {security_reg3_lock_i, security_reg2_lock_i,
                          security_reg1_lock_i, 1'b1};
    assign req_ready_o = (state_q == S_IDLE);
    assign accept      = req_valid_i && req_ready_o;
    assign resp_o      = resp_q;

    // ==========================================================
    // storage
    fam_mem #(.AW(ARRAY_AW)) u_array (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .we_i       (arr_we),
        .waddr_i    (arr_waddr),
        .wdata_i    (arr_wdata),
        .raddr_i    (req_q.addr[ARRAY_AW-1:0]),
        .rdata_o    (arr_rdata)
    );

    fam_mem #(.AW(`FAM_SEC_AW)) u_sec (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .we_i       (sec_we),
        .waddr_i    (sec_waddr),
        .wdata_i    (sec_wdata),
        .raddr_i    ({sec_reg_of(req_q.addr), req_q.addr[7:0]}),
        .rdata_o    (sec_rdata)
    );

    fam_param_rom #(.TABLE_FILL(TABLE_FILL)) u_rom (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .addr_i     (req_q.addr[7:0]),
        .data_o     (rom_rdata)
    );

    // ==========================================================
    // sequencer
    always_comb begin
        state_d   = state_q;
        req_d     = req_q;
        ptr_d     = ptr_q;
        last_d    = last_q;
        sec_tgt_d = sec_tgt_q;
        err_d     = err_q;
        resp_d    = resp_q;
        resp_d.done = 1'b0;
        arr_we    = 1'b0;
        arr_waddr = req_q.addr[ARRAY_AW-1:0];
        arr_wdata = `FAM_ERASED_BYTE;
        sec_we    = 1'b0;
        sec_waddr = {sec_reg_of(req_q.addr), req_q.addr[7:0]};
        sec_wdata = `FAM_ERASED_BYTE;
        case (state_q)
            S_IDLE: begin
                if (accept) begin
                    req_d     = req_i;
                    err_d     = 1'b0;
                    sec_tgt_d = is_sec_op(req_i.op);
                    case (req_i.op)
                        op_read: begin
                            state_d = S_READ;
                        end
                        op_program: begin
                            state_d = S_RMW;
                        end
                        op_sector_erase: begin
                            ptr_d   = req_i.addr[ARRAY_AW-1:0] & ~SECTOR_MASK;
                            last_d  = req_i.addr[ARRAY_AW-1:0] | SECTOR_MASK;
                            state_d = S_ERASE;
                        end
                        op_block_erase: begin
                            ptr_d   = req_i.addr[ARRAY_AW-1:0] & ~BLOCK_MASK;
                            last_d  = req_i.addr[ARRAY_AW-1:0] | BLOCK_MASK;
                            state_d = S_ERASE;
                        end
                        op_chip_erase: begin
                            ptr_d   = '0;
                            last_d  = '1;
                            state_d = S_ERASE;
                        end
                        op_sec_read, read_discoverable_params_cmd: begin
                            if (sec_window_ok(req_i.addr) &&
                                (req_i.op == op_sec_read || req_i.addr[15:8] == 8'h00)) begin
                                state_d = S_READ;
                            end else begin
                                err_d   = 1'b1;
                                state_d = S_RESP;
                            end
                        end
                        op_sec_program, op_sec_erase: begin
                            if (sec_window_ok(req_i.addr) && !locked[sec_reg_of(req_i.addr)]) begin
                                ptr_d   = '0;
                                last_d  = {{(ARRAY_AW-8){1'b0}}, 8'hFF};
                                state_d = (req_i.op == op_sec_erase) ? S_ERASE : S_RMW;
                            end else begin
                                err_d   = 1'b1;
                                state_d = S_RESP;
                            end
                        end
                        default: begin
                            // anything else, page erase included, is refused
                            err_d   = 1'b1;
                            state_d = S_RESP;
                        end
                    endcase
                end
            end
            S_READ: begin
                state_d = S_RESP;
            end
            S_RMW: begin
                state_d = S_MOD;
            end
            S_MOD: begin
                if (sec_tgt_q) begin
                    sec_we    = 1'b1;
                    sec_wdata = sec_rdata & req_q.data;
                end else begin
                    arr_we    = 1'b1;
                    arr_wdata = arr_rdata & req_q.data;
                end
                state_d = S_RESP;
            end
            S_ERASE: begin
                if (sec_tgt_q) begin
                    sec_we    = 1'b1;
                    sec_waddr = {sec_reg_of(req_q.addr), ptr_q[7:0]};
                end else begin
                    arr_we    = 1'b1;
                    arr_waddr = ptr_q;
                end
                if (ptr_q == last_q) begin
                    state_d = S_RESP;
                end else begin
                    ptr_d = ptr_q + 1'b1;
                end
            end
            S_RESP: begin
                resp_d.done = 1'b1;
                resp_d.err  = err_q;
                resp_d.data = `FAM_ERASED_BYTE;
                if (!err_q) begin
                    case (req_q.op)
                        op_read:                      resp_d.data = arr_rdata;
                        read_discoverable_params_cmd: resp_d.data = rom_rdata;
                        op_sec_read: begin
                            resp_d.data = (sec_reg_of(req_q.addr) == 2'd0) ?
                                          rom_rdata : sec_rdata;
                        end
                        default:                      resp_d.data = `FAM_ERASED_BYTE;
                    endcase
                end
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q   <= S_IDLE;
            req_q     <= '0;
            ptr_q     <= '0;
            last_q    <= '0;
            sec_tgt_q <= 1'b0;
            err_q     <= 1'b0;
            resp_q    <= {1'b0, 1'b0, `FAM_ERASED_BYTE};
        end else begin
            state_q   <= state_d;
            req_q     <= req_d;
            ptr_q     <= ptr_d;
            last_q    <= last_d;
            sec_tgt_q <= sec_tgt_d;
            err_q     <= err_d;
            resp_q    <= resp_d;
        end
    end

    // ==========================================================
    // checks
    logic [24:0] erase_writes_q;
    fam_state_t  state_p;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            erase_writes_q <= '0;
            state_p        <= S_IDLE;
        end else begin
            state_p        <= state_q;
            erase_writes_q <= accept ? 25'h000_0000 :
                              (state_q == S_ERASE) ? erase_writes_q + 25'h000_0001 :
                              erase_writes_q;
        end
    end

    sequence s_answer(logic [7:0] b);
        ##3 (resp_o.done && !resp_o.err && resp_o.data == b);
    endsequence

    property p_sig_first;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (accept && req_i.op == read_discoverable_params_cmd && req_i.addr == 24'h00_0000)
            |-> s_answer(`FAM_SIG_0);
    endproperty
    a_sig_first: assert property (p_sig_first) else $error("signature byte wrong");

    property p_rev_minor;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (accept && req_i.op == read_discoverable_params_cmd && req_i.addr == 24'h00_0004)
            |-> s_answer(`FAM_REV_MINOR);
    endproperty
    a_rev_minor: assert property (p_rev_minor) else $error("minor revision wrong");

    property p_reserved_ff;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (accept && req_i.op == read_discoverable_params_cmd && req_i.addr[23:8] == 16'h0000
            && req_i.addr[7:0] >= `FAM_RSVD_BASE) |-> s_answer(`FAM_ERASED_BYTE);
    endproperty
    a_reserved_ff: assert property (p_reserved_ff) else $error("reserved byte not ff");

    property p_param_ro;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        sec_we |-> sec_waddr[9:8] != 2'd0;
    endproperty
    a_param_ro: assert property (p_param_ro) else $error("parameter space written");

    property p_lock_holds;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (accept && (req_i.op == op_sec_program || req_i.op == op_sec_erase)
            && locked[sec_reg_of(req_i.addr)]) |-> ##2 (resp_o.done && resp_o.err);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("locked register accepted");

    property p_sec_confined;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (sec_we && state_q == S_ERASE) |-> sec_waddr[9:8] == sec_reg_of(req_q.addr);
    endproperty
    a_sec_confined: assert property (p_sec_confined) else $error("erase left register");

    property p_clear_only;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (arr_we && state_q == S_MOD) |-> ((arr_wdata & ~arr_rdata) == 8'h00)
            && (arr_waddr[ARRAY_AW-1:8] == req_q.addr[ARRAY_AW-1:8]);
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("program set a bit");

    property p_sector_span;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (state_p == S_ERASE && state_q == S_RESP && req_q.op == op_sector_erase)
            |-> erase_writes_q == `FAM_SECTOR_BYTES;
    endproperty
    a_sector_span: assert property (p_sector_span) else $error("sector erase size wrong");

    property p_sector_aligned;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (arr_we && state_q == S_ERASE && req_q.op == op_sector_erase)
            |-> arr_waddr[ARRAY_AW-1:12] == req_q.addr[ARRAY_AW-1:12];
    endproperty
    a_sector_aligned: assert property (p_sector_aligned) else $error("sector erase strayed");

endmodule
`default_nettype wire

// >>> sim/fam_host_model.sv
// host-side model that issues single byte requests to the address map block
`timescale 1ns/1ps
`default_nettype none

module fam_host_model
    import fam_pkg::*;
(
    input  wire logic    core_clk_i,
    input  wire logic    req_ready_i,
    output var logic     req_valid_o,
    output var fam_req_t req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end

    // =====================================================
    // request driver
    // hold the request until taken; parameter data is fetched with 0x5A or a register 0 security read,
    // and table bytes are read at the fixed offsets the caller gives, not through the header pointer
    task automatic issue(input fam_op_t op, input logic [23:0] addr,
                         input logic [7:0] data, input bit last);
        @(negedge core_clk_i);
        req_valid_o = 1'b1;
        req_o       = '{op: op, addr: addr, data: data};
        while (req_ready_i !== 1'b1) @(negedge core_clk_i);
        @(posedge core_clk_i);
        if (last) begin
            @(negedge core_clk_i);
            req_valid_o = 1'b0;
            req_o       = fam_req_t'({$urandom, 8'($urandom)});
        end
    endtask
endmodule

`default_nettype wire

// >>> sim/tb_fam_top.sv
// self-checking bench for the address map block driven by the host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end

module tb_fam_top
    import fam_pkg::*;
;
    localparam logic [7:0] FILL  = 8'hA5;
    localparam int         LIMIT = 90000;
    logic       core_clk_i = 1'b0;
    logic       reset_n_i  = 1'b0;
    logic       req_valid;
    logic       req_ready;
    fam_req_t   req;
    fam_resp_t  resp;
    logic       lk1        = 1'b0;
    logic       lk2        = 1'b0;
    logic       lk3        = 1'b0;
    logic [8:0] exp_q[$];
    int         error_cnt  = 0;
    int         cmp_count  = 0;
    int         cyc        = 0;

    always #5 core_clk_i = ~core_clk_i;

    fam_top #(.ARRAY_AW(16), .TABLE_FILL(FILL)) dut_u (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid),
        .req_i(req), .security_reg1_lock_i(lk1), .security_reg2_lock_i(lk2),
        .security_reg3_lock_i(lk3), .req_ready_o(req_ready), .resp_o(resp));

    fam_host_model host_u (.core_clk_i(core_clk_i), .req_ready_i(req_ready),
        .req_valid_o(req_valid), .req_o(req));

    // =====================================================
    // response monitor and timeout
    always @(negedge core_clk_i) begin
        logic [8:0] e;
        if (resp.done === 1'b1) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : {1'b1, 8'hxx};
            `CHK("resp", e, {resp.err, resp.data})
        end
    end

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            wrap_up();
        end
    end

    // =====================================================
    // tasks
    task automatic wrap_up;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic go(fam_op_t op, logic [23:0] a, logic [7:0] d, logic e, logic [7:0] x,
                      bit last = 1'b0);
        exp_q.push_back({e, x});
        host_u.issue(op, a, d, last);
    endtask

    task automatic drain;
        int n = 0;
        while (exp_q.size() != 0 && n < 5000) begin
            @(negedge core_clk_i);
            n++;
        end
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("wrong value drain exp 0 got %0d", exp_q.size());
        end
    endtask

    function automatic logic [23:0] sa(int n, logic [7:0] off);
        return {10'h000, 2'(n), 4'h0, off};
    endfunction

    // =====================================================
    // main sequence
    initial begin
        logic [15:0] a;
        logic [7:0]  d1;
        logic [7:0]  d2;
        logic [7:0]  off;
        logic [7:0]  sig[6];
        void'($urandom(10));
        sig = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01};
        repeat (16) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            go(read_discoverable_params_cmd, 24'(i), 8'($urandom), 1'b0, sig[i]);
            go(op_sec_read, 24'(i), 8'($urandom), 1'b0, sig[i]);
        end
        go(read_discoverable_params_cmd, 24'h00_000C, 8'h00, 1'b0, 8'h30);
        go(read_discoverable_params_cmd, 24'h00_0010, 8'h00, 1'b0, 8'hFF);
        go(read_discoverable_params_cmd, 24'h00_0030, 8'h00, 1'b0, FILL);
        go(read_discoverable_params_cmd, 24'h00_006F, 8'h00, 1'b0, FILL);
        go(read_discoverable_params_cmd, 24'h00_0070, 8'h00, 1'b0, 8'hFF);
        go(read_discoverable_params_cmd, 24'h00_0100, 8'h00, 1'b1, 8'hFF);
        go(op_sec_program, 24'h00_0000, 8'h00, 1'b1, 8'hFF);
        go(op_sec_erase, 24'h00_0000, 8'h00, 1'b1, 8'hFF);
        go(read_discoverable_params_cmd, 24'h00_0000, 8'h00, 1'b0, 8'h53, 1'b1);
        drain();
        a  = {4'h8, 12'($urandom)};
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        go(op_program, 24'(a), d1, 1'b0, 8'hFF);
        go(op_read, 24'(a), 8'h00, 1'b0, d1);
        go(op_program, 24'(a), d2, 1'b0, 8'hFF);
        go(op_program, 24'(a ^ 16'h0100), 8'h00, 1'b0, 8'hFF);
        go(fam_op_t'(8'h09), 24'(a), 8'h00, 1'b1, 8'hFF);
        go(op_read, 24'(a), 8'h00, 1'b0, d1 & d2);
        go(op_program, 24'h00_5FFF, 8'h00, 1'b0, 8'hFF);
        go(op_program, 24'h00_6000, 8'h00, 1'b0, 8'hFF);
        go(op_sector_erase, {12'h005, 12'($urandom)}, 8'h00, 1'b0, 8'hFF);
        go(op_read, 24'h00_5FFF, 8'h00, 1'b0, 8'hFF);
        go(op_read, 24'h00_6000, 8'h00, 1'b0, 8'h00, 1'b1);
        drain();
        off = 8'($urandom);
        for (int n = 1; n < 4; n++) begin
            go(op_sec_program, sa(n, off), 8'h3C ^ 8'(n), 1'b0, 8'hFF);
            go(op_sec_read, sa(n, off), 8'h00, 1'b0, 8'h3C ^ 8'(n));
            go(op_read, sa(n, off), 8'h00, 1'b0, 8'hFF, n == 3);
        end
        drain();
        lk1 = 1'b1;
        lk3 = 1'b1;
        go(op_sec_program, sa(1, off), 8'h00, 1'b1, 8'hFF);
        go(op_sec_program, sa(3, off), 8'h00, 1'b1, 8'hFF);
        go(op_sec_erase, sa(2, 8'h00), 8'h00, 1'b0, 8'hFF);
        go(op_sec_read, sa(2, off), 8'h00, 1'b0, 8'hFF);
        go(op_sec_read, sa(1, off), 8'h00, 1'b0, 8'h3D);
        go(op_sec_read, sa(3, off), 8'h00, 1'b0, 8'h3F);
        go(op_sec_read, 24'h00_31FF, 8'h00, 1'b1, 8'hFF, 1'b1);
        drain();
        lk2 = 1'b1;
        go(op_sec_program, sa(2, off), 8'h00, 1'b1, 8'hFF);
        go(op_sec_read, sa(2, off), 8'h00, 1'b0, 8'hFF);
        go(op_block_erase, {8'h00, 16'($urandom)}, 8'h00, 1'b0, 8'hFF);
        go(op_read, 24'h00_6000, 8'h00, 1'b0, 8'hFF);
        go(op_read, 24'(a), 8'h00, 1'b0, 8'hFF, 1'b1);
        drain();
        wrap_up();
    end
endmodule

`default_nettype wire
